// file: rtl/tec_edge_det.sv
`timescale 1ns/100ps
module tec_edge_det
  import tec_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic pin_in,
  input wire logic [1:0] sel_in,
  output logic valid_out
);
  logic s1_q;
  logic s2_q;
  logic prev_q;
  wire rise = s2_q & ~prev_q;
  wire fall = ~s2_q & prev_q;

  // two-stage synchroniser, then edge qualification by select
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  assign valid_out = (sel_in == EDGE_RISE) ? rise :
                     (sel_in == EDGE_FALL) ? fall :
                     (sel_in == EDGE_BOTH) ? (rise | fall) : 1'b0;
endmodule

// file: rtl/tec_pkg.sv
package tec_pkg;
  localparam logic [7:0] ADDR_CTL0 = 8'h00;
  localparam logic [7:0] ADDR_CTL1 = 8'h04;
  localparam logic [7:0] ADDR_IOC0 = 8'h08;
  localparam logic [7:0] ADDR_IOC1 = 8'h0C;
  localparam logic [7:0] ADDR_IOC2 = 8'h10;
  localparam logic [7:0] ADDR_OPT0 = 8'h14;
  localparam logic [7:0] ADDR_CAPCMP0 = 8'h18;
  localparam logic [7:0] ADDR_CNT = 8'h28;
  localparam logic [7:0] ADDR_ISTAT = 8'h2C;
  localparam logic [7:0] ADDR_IMASK = 8'h30;
  localparam int CE_BIT = 7;
  localparam int EEE_BIT = 5;
  localparam int OVF_BIT = 0;
  localparam int CCS_LSB = 1;
  localparam int NCH = 4;
  localparam logic [15:0] CNT_STOP = 16'hFFFF;
  localparam logic [15:0] CNT_READ_STOP = 16'h0000;
  localparam logic [15:0] CCR_RST = 16'h0000;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [2:0] MODE_EVENT = 3'h1;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// file: rtl/tec_timer.sv
`timescale 1ns/100ps
module tec_timer
  import tec_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [3:0] TIMER_IN_IN,
  output logic [3:0] TIMER_OUT_OUT,
  output logic [3:0] MATCH_CAPTURE_IRQ_OUT,
  output logic OVERFLOW_IRQ_OUT,
  output logic IRQ_OUT
);
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [7:0] ioc0_q;
  logic [7:0] ioc1_q;
  logic [7:0] ioc2_q;
  logic [4:0] opt_sel_q;
  logic ovf_flag_q;
  logic [15:0] ccr_q [NCH];
  logic [15:0] cbuf_q [NCH];
  logic [15:0] cnt_q;
  logic started_q;
  logic adv_q;
  logic [6:0] pre_q;
  logic [NCH-1:0] tog_q;
  logic [4:0] istat_q;
  logic [4:0] imask_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [3:0] tout_q;
  logic [3:0] mc_irq_q;
  logic ov_irq_q;
  logic irq_q;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic [3:0] out_lvl;

  function automatic logic div_hit(input logic [2:0] k, input logic [6:0] p);
    logic [6:0] m;
    m = 7'((8'h01 << k) - 8'h01);
    return (p & m) == m;
  endfunction

  wire ce = ctl0_q[CE_BIT];
  wire [2:0] cks = ctl0_q[2:0];
  wire [2:0] mode = ctl1_q[2:0];
  wire ext_clk = ctl1_q[EEE_BIT] | (mode == MODE_EVENT);
  wire access = PSEL_IN & PENABLE_IN;
  wire wr_en = access & pready_q & PWRITE_IN;
  wire rd_take = access & ~pready_q;
  wire [15:0] wdata16 = PWDATA_IN[15:0];
  wire [15:0] cnt_view = ce ? cnt_q : CNT_READ_STOP;

  // edge detectors: inputs 0..3 for capture, input 0 again for event counting
  logic [NCH-1:0] cap_edge;
  logic ev_edge;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_edge
      tec_edge_det u_det (
        .clk_in(SYS_CLK_IN),
        .rstn_in(RSTN_IN),
        .pin_in(TIMER_IN_IN[gi]),
        .sel_in(ioc1_q[2*gi +: 2]),
        .valid_out(cap_edge[gi])
      );
    end
  endgenerate

  tec_edge_det u_event (
    .clk_in(SYS_CLK_IN),
    .rstn_in(RSTN_IN),
    .pin_in(TIMER_IN_IN[0]),
    .sel_in(ioc2_q[1:0]),
    .valid_out(ev_edge)
  );

  wire tick = ce & (ext_clk ? ev_edge : div_hit(cks, pre_q));
  wire wrap = tick & started_q & (cnt_q == CNT_STOP);

  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] match_ev;
  logic [NCH-1:0] ccr_wr;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      assign ccr_wr[gi] = wr_en & (PADDR_IN == ADDR_CAPCMP0 + 8'(4 * gi));
      assign cap_ev[gi] = ce & opt_sel_q[CCS_LSB + gi] & cap_edge[gi];
      assign match_ev[gi] = adv_q & ~opt_sel_q[CCS_LSB + gi] & (cnt_q == cbuf_q[gi]);

      always_ff @(posedge SYS_CLK_IN)
      begin
        if (!RSTN_IN)
        begin
          ccr_q[gi] <= CCR_RST;
          cbuf_q[gi] <= CCR_RST;
          tog_q[gi] <= 1'b0;
        end
        else
        begin
          if (cap_ev[gi])
            ccr_q[gi] <= cnt_q;
          else if (ccr_wr[gi])
            ccr_q[gi] <= wdata16;
          // buffer loads the bus data directly on its register write, only while the channel is in compare mode
          if (ccr_wr[gi] && !opt_sel_q[CCS_LSB + gi])
            cbuf_q[gi] <= wdata16;
          if (!ce)
            tog_q[gi] <= 1'b0;
          else if (match_ev[gi] && ioc0_q[2*gi])
            tog_q[gi] <= ~tog_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      cnt_q <= CNT_STOP;
      started_q <= 1'b0;
      adv_q <= 1'b0;
      pre_q <= 7'h00;
    end
    else if (!ce)
    begin
      cnt_q <= CNT_STOP;
      started_q <= 1'b0;
      adv_q <= 1'b0;
      pre_q <= 7'h00;
    end
    else
    begin
      pre_q <= pre_q + 7'h01;
      adv_q <= tick;
      if (tick)
      begin
        cnt_q <= cnt_q + 16'h0001;
        started_q <= 1'b1;
      end
    end
  end

  // overflow flag: cleared by writing 0, set wins over the clear
  wire opt_wr = wr_en & (PADDR_IN == ADDR_OPT0);
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RSTN_IN)
      ovf_flag_q <= 1'b0;
    else if (!ce)
      ovf_flag_q <= 1'b0;
    else if (wrap)
      ovf_flag_q <= 1'b1;
    else if (opt_wr && !PWDATA_IN[OVF_BIT])
      ovf_flag_q <= 1'b0;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      ctl0_q <= REG8_RST;
      ctl1_q <= REG8_RST;
      ioc0_q <= REG8_RST;
      ioc1_q <= REG8_RST;
      ioc2_q <= REG8_RST;
      opt_sel_q <= 5'h00;
      imask_q <= 5'h00;
    end
    else if (wr_en)
    begin
      if (PADDR_IN == ADDR_CTL0)
        ctl0_q <= PWDATA_IN[7:0] & 8'h87;
      if (PADDR_IN == ADDR_CTL1)
        ctl1_q <= PWDATA_IN[7:0] & 8'h27;
      if (PADDR_IN == ADDR_IOC0)
        ioc0_q <= PWDATA_IN[7:0];
      if (PADDR_IN == ADDR_IOC1)
        ioc1_q <= PWDATA_IN[7:0];
      if (PADDR_IN == ADDR_IOC2)
        ioc2_q <= PWDATA_IN[7:0] & 8'h0F;
      if (opt_wr)
        opt_sel_q <= PWDATA_IN[4:0] & 5'h1E;
      if (PADDR_IN == ADDR_IMASK)
        imask_q <= PWDATA_IN[4:0];
    end
  end

  wire [4:0] ev_all = {wrap, cap_ev | match_ev};
  wire istat_wr = wr_en & (PADDR_IN == ADDR_ISTAT);
  wire [4:0] istat_clr = istat_wr ? PWDATA_IN[4:0] : 5'h00;

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      istat_q <= 5'h00;
      mc_irq_q <= 4'h0;
      ov_irq_q <= 1'b0;
      irq_q <= 1'b0;
      tout_q <= 4'h0;
    end
    else
    begin
      istat_q <= (istat_q & ~istat_clr) | ev_all;
      mc_irq_q <= ev_all[3:0];
      ov_irq_q <= wrap;
      irq_q <= |(istat_q & imask_q);
      tout_q <= out_lvl;
    end
  end

  // output level: start level when idle, toggled on own match while enabled
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_out
      assign out_lvl[gi] = ioc0_q[2*gi+1] ^ (ioc0_q[2*gi] & ce & tog_q[gi]);
    end
  endgenerate

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (PADDR_IN)
      ADDR_CTL0: rd_mux = {24'h000000, ctl0_q};
      ADDR_CTL1: rd_mux = {24'h000000, ctl1_q};
      ADDR_IOC0: rd_mux = {24'h000000, ioc0_q};
      ADDR_IOC1: rd_mux = {24'h000000, ioc1_q};
      ADDR_IOC2: rd_mux = {24'h000000, ioc2_q};
      ADDR_OPT0: rd_mux = {27'h0000000, opt_sel_q[4:1], ovf_flag_q};
      ADDR_CAPCMP0: rd_mux = {16'h0000, ccr_q[0]};
      ADDR_CAPCMP0 + 8'h04: rd_mux = {16'h0000, ccr_q[1]};
      ADDR_CAPCMP0 + 8'h08: rd_mux = {16'h0000, ccr_q[2]};
      ADDR_CAPCMP0 + 8'h0C: rd_mux = {16'h0000, ccr_q[3]};
      ADDR_CNT: rd_mux = {16'h0000, cnt_view};
      ADDR_ISTAT: rd_mux = {27'h0000000, istat_q};
      ADDR_IMASK: rd_mux = {27'h0000000, imask_q};
      default: rd_ok = 1'b0;
    endcase
  end

  // one wait state on every access; data and error sampled with it
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= rd_take;
      if (rd_take)
      begin
        prdata_q <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
        pslverr_q <= ~rd_ok;
      end
      else
        pslverr_q <= 1'b0;
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign TIMER_OUT_OUT = tout_q;
  assign MATCH_CAPTURE_IRQ_OUT = mc_irq_q;
  assign OVERFLOW_IRQ_OUT = ov_irq_q;
  assign IRQ_OUT = irq_q;

  sequence s_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence s_access;
    PSEL_IN && PENABLE_IN;
  endsequence

  a_stop_holds_ffff: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    !ce && !$past(ce) |-> cnt_q == CNT_STOP) else $error("stopped counter not FFFF");
  a_stop_reads_zero: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    rd_take && !PWRITE_IN && PADDR_IN == ADDR_CNT && !ce |=> PRDATA_OUT == 32'h0)
    else $error("stopped count read not zero");
  a_count_step: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    tick && ce |=> cnt_q == $past(cnt_q) + 16'h0001 || !ce) else $error("counter did not step");
  a_div_tick_gap: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    ce && !ext_clk && cks != 3'h0 && tick ##1 ce && $stable(ctl0_q) |-> !tick)
    else $error("divided clock ticked twice");
  a_match_irq: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    adv_q && !opt_sel_q[CCS_LSB] && cnt_q == cbuf_q[0] |=> MATCH_CAPTURE_IRQ_OUT[0])
    else $error("match without interrupt");
  a_ovf_irq: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    wrap |=> OVERFLOW_IRQ_OUT && cnt_q == 16'h0000) else $error("wrap without overflow");
  a_buffer_load: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    ccr_wr[0] && !opt_sel_q[CCS_LSB] |=> cbuf_q[0] == $past(wdata16))
    else $error("compare buffer not loaded");
  a_capture_store: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    cap_ev[2] |=> ccr_q[2] == $past(cnt_q) && MATCH_CAPTURE_IRQ_OUT[2])
    else $error("capture not stored");
  a_sticky_set_wins: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    ev_all[2] |=> istat_q[2]) else $error("event lost against clear");
  a_out_idle_level: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    !ce ##1 !ce && $stable(ioc0_q) |-> TIMER_OUT_OUT[0] == ioc0_q[1])
    else $error("idle output not start level");
  a_apb_wait_one: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    s_setup ##1 s_access |-> !PREADY_OUT ##1 PREADY_OUT) else $error("pready timing wrong");
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
  import tec_pkg::*;
  logic clk, rstn, psel, pen, pwr, pready, pslverr, ovf, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v0;
  logic [3:0] lvl, tin, tout, mirq;
  int n_mismatch, checked, cyc, t0, ev[5], e;
  int xp[4] = '{0, 1, 1, 2};
  tec_timer uut (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TIMER_IN_IN(tin), .TIMER_OUT_OUT(tout),
    .MATCH_CAPTURE_IRQ_OUT(mirq), .OVERFLOW_IRQ_OUT(ovf), .IRQ_OUT(irq));
  tec_pulse_src src (.clk_in(clk), .lvl_in(lvl), .pin_out(tin));
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++)
      ev[i] <= ev[i] + int'(mirq[i] === 1'b1);
    ev[4] <= ev[4] + int'(ovf === 1'b1);
  end
  task automatic results;
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer; read data and slave error taken at the ready edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    t0 = cyc;
    psel <= 1'b0;
    pen <= 1'b0;
    `CHK(k, 2)
  endtask
  task automatic wev(input int n, input int tgt, input int lim);
    int k;
    k = 0;
    while (ev[n] < tgt && k < lim)
    begin
      @(posedge clk);
      k++;
    end
    `CHK(ev[n] >= tgt, 1'b1)
  endtask
  task automatic pulse(input int n);
    lvl[n] <= 1'b1;
    repeat (6) @(posedge clk);
    lvl[n] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial
  begin
    #(90000 * 50);
    n_mismatch++;
    results();
  end
  initial
  begin
    clk = 0;
    rstn = 0;
    psel = 0;
    pen = 0;
    pwr = 0;
    paddr = 0;
    pwdata = 0;
    lvl = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    acc(0, ADDR_CNT, 0);
    `CHK(rd, 32'h0)
    acc(0, ADDR_CAPCMP0 + 8'h08, 0);
    `CHK(rd, 32'h0)
    acc(0, 8'h3C, 0);
    `CHK(err, 1'b1)
    acc(1, ADDR_IOC0, 32'h83);
    repeat (2) @(posedge clk);
    `CHK(tout[0], 1'b1)
    `CHK(tout[3:1], 3'h4)
    acc(1, ADDR_IMASK, 32'h1);
    acc(1, ADDR_CAPCMP0, 32'h20);
    acc(1, ADDR_CTL0, 32'h80);
    wev(0, 1, 100);
    `CHK(ev[1] + ev[3], 2)
    repeat (3) @(posedge clk);
    `CHK(tout[0], 1'b0)
    `CHK(irq, 1'b1)
    acc(0, ADDR_ISTAT, 0);
    `CHK(rd, 32'h0F)
    acc(1, ADDR_ISTAT, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    acc(0, ADDR_CNT, 0);
    v0 = rd;
    e = t0;
    acc(0, ADDR_CNT, 0);
    `CHK(rd - v0, 32'(t0 - e))
    wev(4, 1, 66000);
    acc(0, ADDR_ISTAT, 0);
    `CHK(rd, 32'h1E)
    acc(0, ADDR_OPT0, 0);
    `CHK(rd, 32'h1)
    acc(1, ADDR_CTL0, 32'h0);
    acc(0, ADDR_CNT, 0);
    `CHK(rd, 32'h0)
    acc(0, ADDR_OPT0, 0);
    `CHK(rd, 32'h0)
    `CHK(tout[0], 1'b1)
    acc(1, ADDR_CTL0, 32'h83);
    repeat (16) @(posedge clk);
    acc(0, ADDR_CNT, 0);
    v0 = rd;
    e = t0;
    repeat (80) @(posedge clk);
    acc(0, ADDR_CNT, 0);
    `CHK(rd - v0 >= 32'((t0 - e) / 8) && rd - v0 <= 32'((t0 - e) / 8 + 1), 1'b1)
    acc(1, ADDR_CTL0, 32'h0);
    acc(1, ADDR_CTL1, {29'h0, MODE_EVENT});
    acc(1, ADDR_IOC2, 32'h1);
    acc(1, ADDR_CTL0, 32'h80);
    for (int i = 0; i < 3; i++)
      pulse(0);
    acc(0, ADDR_CNT, 0);
    `CHK(rd, 32'h2)
    acc(1, ADDR_CTL0, 32'h0);
    acc(1, ADDR_CTL1, 32'h0);
    acc(1, ADDR_OPT0, 32'h8);
    acc(1, ADDR_CTL0, 32'h80);
    for (int m = 0; m < 4; m++)
    begin
      acc(1, ADDR_IOC1, 32'(m) << 4);
      e = ev[2];
      pulse(2);
      `CHK(ev[2] - e, xp[m])
    end
    acc(0, ADDR_CAPCMP0 + 8'h08, 0);
    v0 = rd;
    acc(0, ADDR_CNT, 0);
    `CHK(v0 != 0 && v0 < rd, 1'b1)
    results();
  end
endmodule

// file: verif/tec_pulse_src.sv
`timescale 1ns/100ps
module tec_pulse_src (
  input wire logic clk_in,
  input wire logic [3:0] lvl_in,
  output logic [3:0] pin_out
);
  initial pin_out = 4'h0;
  // external source: pins follow the requested level one clock later
  always @(posedge clk_in)
  begin
    pin_out <= lvl_in;
  end
endmodule
